// ---- cte_exec.sv ----
// Execution unit for data transfer and integer arithmetic instructions
`default_nettype none
// What this block does
// - Moves byte, word, long between registers, memory, and immediate into register.
// - Peripheral-synchronised byte load and store are refused as illegal.
// - Single restore loads register from stack top then increments stack pointer.
// - Single save decrements stack pointer then stores the register there.
// - Multi restore reloads two or more long registers with post-increment.
// - Multi save stores two or more long registers with pre-decrement.
// - Add or subtract register or immediate into destination, all three sizes.
// - Subtract with byte immediate is refused as illegal.
// - Carry sum and borrow difference work on bytes only, using carry flag.
// - Step up and down change a register by one or two.
// - Byte steps allow only one; two needs word or long.
// - Address add and subtract apply 1, 2 or 4 to a long register.
// - Decimal adjust corrects byte sum or difference to BCD using flags.
// - Unsigned multiply: 8x8 to 16 or 16x16 to 32 bits.
// - Signed multiply: two's-complement, 8x8 to 16 or 16x16 to 32.
// - Registers alias as sixteen bytes, sixteen words and eight longs.
// - Flags register holds negative, zero, overflow and carry.
module cte_exec (
  input wire logic clk,
  input wire logic nrst,
  input wire logic instrValid,
  input wire cte_pkg::cte_instr_s instr,
  output logic instrReady,
  output logic illegal,
  output logic busy,
  output cte_pkg::cte_mem_s memReq,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  output logic [7:0] conditionFlags,
  output logic [31:0] wideGpr [cte_pkg::NUM_WIDE_GPR]
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_MEM = 5'b00010,
    ST_MULTI = 5'b00100,
    ST_MUL = 5'b01000,
    ST_DONE = 5'b10000
  } cte_state_e;

  typedef struct packed {
    cte_state_e state;
    cte_pkg::cte_instr_s cur;
    logic [7:0] flags;
    logic [7:0] listLeft;
    logic [31:0] sp;
    logic memPending;
    logic illegal;
  } cte_exec_s;

  cte_exec_s state_ff;
  cte_exec_s nxt_state;

  logic [31:0] rdVal;
  logic [31:0] rsVal;
  logic [31:0] spVal;
  logic wrEn;
  logic [3:0] wrIdx;
  cte_pkg::cte_size_e wrSize;
  logic [31:0] wrData;
  logic mulStart;
  logic [31:0] mulProduct;
  logic mulDone;
  logic [3:0] rdSel;
  cte_pkg::cte_size_e rdSz;

  // Destination read port follows the latched instruction during multi-cycle work
  assign rdSel = (state_ff.state == ST_IDLE) ? instr.rd : state_ff.cur.rd;
  assign rdSz = (state_ff.state == ST_IDLE) ? instr.size : state_ff.cur.size;

  cte_gpr_file u_gpr (
    .clk(clk),
    .nrst(nrst),
    .rdIdx(rdSel),
    .rdSize(rdSz),
    .rsIdx(instr.rs),
    .rsSize(instr.size),
    .wrEn(wrEn),
    .wrIdx(wrIdx),
    .wrSize(wrSize),
    .wrData(wrData),
    .rdVal(rdVal),
    .rsVal(rsVal),
    .spVal(spVal),
    .wideGpr(wideGpr)
  );

  cte_multiplier u_mul (
    .clk(clk),
    .nrst(nrst),
    .start(mulStart),
    .isSigned(instr.op == cte_pkg::OP_SIGNED_MULTIPLY),
    .isWord(instr.size == cte_pkg::SZ_WORD),
    .opA(rdVal[15:0]),
    .opB(rsVal[15:0]),
    .product(mulProduct),
    .done(mulDone)
  );

  // Operand width in bytes for stack pointer stepping
  function automatic logic [31:0] sizeBytes(input cte_pkg::cte_size_e sz);
    case (sz)
      cte_pkg::SZ_BYTE: sizeBytes = 32'h1;
      cte_pkg::SZ_WORD: sizeBytes = 32'h2;
      default: sizeBytes = 32'h4;
    endcase
  endfunction : sizeBytes

  // Sign bit position at size
  function automatic logic msbAt(input logic [31:0] v, input cte_pkg::cte_size_e sz);
    case (sz)
      cte_pkg::SZ_BYTE: msbAt = v[7];
      cte_pkg::SZ_WORD: msbAt = v[15];
      default: msbAt = v[31];
    endcase
  endfunction : msbAt

  function automatic logic [31:0] maskAt(input logic [31:0] v, input cte_pkg::cte_size_e sz);
    case (sz)
      cte_pkg::SZ_BYTE: maskAt = {24'h0, v[7:0]};
      cte_pkg::SZ_WORD: maskAt = {16'h0, v[15:0]};
      default: maskAt = v;
    endcase
  endfunction : maskAt

  // Main sequencing and datapath
  always_comb begin
    logic [31:0] opB;
    logic [32:0] sum;
    logic isSub;
    logic useCarry;
    logic [31:0] res;
    logic carryOut;
    logic [7:0] adj;
    logic bcdC;
    logic [3:0] nextReg;
    nxt_state = state_ff;
    opB = 32'h0;
    sum = 33'h0;
    isSub = 1'b0;
    useCarry = 1'b0;
    res = 32'h0;
    carryOut = 1'b0;
    adj = 8'h00;
    bcdC = 1'b0;
    nextReg = 4'h0;
    wrEn = 1'b0;
    wrIdx = instr.rd;
    wrSize = instr.size;
    wrData = 32'h0;
    mulStart = 1'b0;
    memReq = '0;
    nxt_state.illegal = 1'b0;
    case (state_ff.state)
      ST_IDLE: begin
        if (instrValid) begin
          nxt_state.cur = instr;
          case (instr.op)
            cte_pkg::OP_TRANSFER: begin
              if (instr.src == cte_pkg::SRC_MEM || instr.toMem) begin
                nxt_state.state = ST_MEM;
              end else begin
                wrEn = 1'b1;
                wrData = (instr.src == cte_pkg::SRC_IMM) ? instr.imm : rsVal;
                nxt_state.state = ST_DONE;
              end
            end
            cte_pkg::OP_PERIPH_SYNC_LOAD, cte_pkg::OP_PERIPH_SYNC_STORE: begin
              nxt_state.illegal = 1'b1;
              nxt_state.state = ST_DONE;
            end
            cte_pkg::OP_STACK_RESTORE, cte_pkg::OP_STACK_SAVE: begin
              if (instr.size == cte_pkg::SZ_BYTE) begin
                nxt_state.illegal = 1'b1;
                nxt_state.state = ST_DONE;
              end else begin
                nxt_state.sp = spVal;
                nxt_state.state = ST_MEM;
              end
            end
            cte_pkg::OP_MULTI_RESTORE, cte_pkg::OP_MULTI_SAVE: begin
              if ($countones(instr.regList) < 2) begin
                nxt_state.illegal = 1'b1;
                nxt_state.state = ST_DONE;
              end else begin
                nxt_state.sp = spVal;
                nxt_state.listLeft = instr.regList;
                nxt_state.state = ST_MULTI;
              end
            end
            cte_pkg::OP_ADD, cte_pkg::OP_SUB,
            cte_pkg::OP_CARRY_SUM, cte_pkg::OP_BORROW_DIFF: begin
              isSub = (instr.op == cte_pkg::OP_SUB) || (instr.op == cte_pkg::OP_BORROW_DIFF);
              useCarry = (instr.op == cte_pkg::OP_CARRY_SUM) ||
                         (instr.op == cte_pkg::OP_BORROW_DIFF);
              if ((instr.op == cte_pkg::OP_SUB && instr.src == cte_pkg::SRC_IMM &&
                   instr.size == cte_pkg::SZ_BYTE) ||
                  (useCarry && instr.size != cte_pkg::SZ_BYTE) ||
                  instr.src == cte_pkg::SRC_MEM) begin
                nxt_state.illegal = 1'b1;
              end else begin
                opB = maskAt((instr.src == cte_pkg::SRC_IMM) ? instr.imm : rsVal, instr.size);
                // Subtraction as add of complement; carry-in forms borrow
                if (isSub) begin
                  sum = {1'b0, rdVal} + {1'b0, maskAt(~opB, instr.size)} +
                        {32'h0, ~(useCarry & state_ff.flags[cte_pkg::FLAG_C])};
                end else begin
                  sum = {1'b0, rdVal} + {1'b0, opB} +
                        {32'h0, useCarry & state_ff.flags[cte_pkg::FLAG_C]};
                end
                res = maskAt(sum[31:0], instr.size);
                case (instr.size)
                  cte_pkg::SZ_BYTE: carryOut = sum[8];
                  cte_pkg::SZ_WORD: carryOut = sum[16];
                  default: carryOut = sum[32];
                endcase
                wrEn = 1'b1;
                wrData = res;
                // Flags at operand size; carry is borrow for subtraction
                nxt_state.flags[cte_pkg::FLAG_N] = msbAt(res, instr.size);
                nxt_state.flags[cte_pkg::FLAG_V] =
                  (msbAt(rdVal, instr.size) == (msbAt(opB, instr.size) ^ isSub)) &&
                  (msbAt(res, instr.size) != msbAt(rdVal, instr.size));
                nxt_state.flags[cte_pkg::FLAG_C] = carryOut ^ isSub;
                // Carry forms only keep zero clear, so multi-byte chains test correctly
                if (useCarry) begin
                  nxt_state.flags[cte_pkg::FLAG_Z] =
                    state_ff.flags[cte_pkg::FLAG_Z] & (res == 32'h0);
                end else begin
                  nxt_state.flags[cte_pkg::FLAG_Z] = (res == 32'h0);
                end
              end
              nxt_state.state = ST_DONE;
            end
            cte_pkg::OP_STEP_UP, cte_pkg::OP_STEP_DOWN: begin
              if (instr.imm[1:0] != 2'h1 &&
                  (instr.imm[1:0] != 2'h2 || instr.size == cte_pkg::SZ_BYTE)) begin
                nxt_state.illegal = 1'b1;
              end else begin
                res = (instr.op == cte_pkg::OP_STEP_UP) ? rdVal + {30'h0, instr.imm[1:0]} :
                      rdVal - {30'h0, instr.imm[1:0]};
                wrEn = 1'b1;
                wrData = maskAt(res, instr.size);
                nxt_state.flags[cte_pkg::FLAG_N] = msbAt(res, instr.size);
                nxt_state.flags[cte_pkg::FLAG_Z] = (maskAt(res, instr.size) == 32'h0);
              end
              nxt_state.state = ST_DONE;
            end
            cte_pkg::OP_ADDR_PLUS, cte_pkg::OP_ADDR_MINUS: begin
              if (instr.size != cte_pkg::SZ_LONG ||
                  !(instr.imm[2:0] inside {3'h1, 3'h2, 3'h4})) begin
                nxt_state.illegal = 1'b1;
              end else begin
                wrEn = 1'b1; // Flags untouched
                wrData = (instr.op == cte_pkg::OP_ADDR_PLUS) ?
                         rdVal + {29'h0, instr.imm[2:0]} :
                         rdVal - {29'h0, instr.imm[2:0]};
              end
              nxt_state.state = ST_DONE;
            end
            cte_pkg::OP_BCD_FIX_SUM, cte_pkg::OP_BCD_FIX_DIFF: begin
              // Uses carry from prior op; half-carry not held, so low digit judged by value
              bcdC = state_ff.flags[cte_pkg::FLAG_C];
              if (instr.op == cte_pkg::OP_BCD_FIX_SUM) begin
                if (rdVal[3:0] > 4'h9) adj[3:0] = 4'h6;
                if (bcdC || rdVal[7:0] > 8'h99) begin
                  adj[7:4] = 4'h6;
                  bcdC = 1'b1;
                end
                res = {24'h0, rdVal[7:0] + adj};
              end else begin
                if (rdVal[3:0] > 4'h9) adj[3:0] = 4'h6;
                if (bcdC) adj[7:4] = 4'h6;
                res = {24'h0, rdVal[7:0] - adj};
              end
              wrEn = 1'b1;
              wrSize = cte_pkg::SZ_BYTE;
              wrData = res;
              nxt_state.flags[cte_pkg::FLAG_C] = bcdC;
              nxt_state.flags[cte_pkg::FLAG_N] = res[7];
              nxt_state.flags[cte_pkg::FLAG_Z] = (res[7:0] == 8'h00);
              nxt_state.state = ST_DONE;
            end
            cte_pkg::OP_UNSIGNED_MULTIPLY, cte_pkg::OP_SIGNED_MULTIPLY: begin
              if (instr.size == cte_pkg::SZ_LONG) begin
                nxt_state.illegal = 1'b1;
                nxt_state.state = ST_DONE;
              end else begin
                mulStart = 1'b1;
                nxt_state.state = ST_MUL;
              end
            end
            default: begin
              nxt_state.illegal = 1'b1;
              nxt_state.state = ST_DONE;
            end
          endcase
        end
      end
      ST_MEM: begin
        // Single memory or stack access, held until acknowledged
        memReq.req = 1'b1;
        memReq.size = state_ff.cur.size;
        memReq.addr = state_ff.cur.addr;
        memReq.write = state_ff.cur.toMem || (state_ff.cur.op == cte_pkg::OP_STACK_SAVE);
        memReq.wdata = rdVal;
        if (state_ff.cur.op == cte_pkg::OP_STACK_RESTORE) begin
          memReq.addr = state_ff.sp;
        end else if (state_ff.cur.op == cte_pkg::OP_STACK_SAVE) begin
          memReq.addr = state_ff.sp - sizeBytes(state_ff.cur.size);
        end
        if (memAck) begin
          if (!memReq.write) begin
            wrEn = 1'b1;
            wrIdx = state_ff.cur.rd;
            wrSize = state_ff.cur.size;
            wrData = maskAt(memRdata, state_ff.cur.size);
          end else if (state_ff.cur.op == cte_pkg::OP_STACK_SAVE) begin
            wrEn = 1'b1;
            wrIdx = 4'(cte_pkg::STACK_REG);
            wrSize = cte_pkg::SZ_LONG;
            wrData = memReq.addr;
          end
          nxt_state.state = ST_DONE;
        end
      end
      ST_MULTI: begin
        // Restore walks low to high, save high to low, so the pair mirror each other
        nextReg = 4'h0;
        for (int i = cte_pkg::NUM_WIDE_GPR - 1; i >= 0; i--) begin
          if (state_ff.cur.op == cte_pkg::OP_MULTI_RESTORE) begin
            if (state_ff.listLeft[i]) nextReg = 4'(i); // Lowest set wins
          end else if (state_ff.listLeft[cte_pkg::NUM_WIDE_GPR-1-i]) begin
            nextReg = 4'(7 - i); // Highest set wins
          end
        end
        memReq.req = 1'b1;
        memReq.size = cte_pkg::SZ_LONG;
        memReq.write = (state_ff.cur.op == cte_pkg::OP_MULTI_SAVE);
        memReq.wdata = wideGpr[nextReg[2:0]];
        memReq.addr = memReq.write ? state_ff.sp - 32'h4 : state_ff.sp;
        if (memAck) begin
          if (!memReq.write) begin
            wrEn = 1'b1;
            wrIdx = nextReg;
            wrSize = cte_pkg::SZ_LONG;
            wrData = memRdata;
            nxt_state.sp = state_ff.sp + 32'h4;
          end else begin
            nxt_state.sp = state_ff.sp - 32'h4;
          end
          nxt_state.listLeft[nextReg[2:0]] = 1'b0;
          if ((state_ff.listLeft & ~(8'h01 << nextReg[2:0])) == 8'h00) begin
            nxt_state.state = ST_DONE;
          end
        end
      end
      ST_MUL: begin
        if (mulDone) begin
          wrEn = 1'b1;
          // Byte halves of register n widen into word n, the low half of that register
          wrIdx = (state_ff.cur.size == cte_pkg::SZ_BYTE) ? {1'b0, state_ff.cur.rd[2:0]} :
                  state_ff.cur.rd;
          // Product widens the destination: word for byte ops, long for word ops
          wrSize = (state_ff.cur.size == cte_pkg::SZ_BYTE) ? cte_pkg::SZ_WORD :
                   cte_pkg::SZ_LONG;
          wrData = mulProduct;
          nxt_state.state = ST_DONE;
        end
      end
      ST_DONE: begin
        // Restore post-increment and multi sp update land here
        if (state_ff.cur.op == cte_pkg::OP_STACK_RESTORE) begin
          wrEn = 1'b1;
          wrIdx = 4'(cte_pkg::STACK_REG);
          wrSize = cte_pkg::SZ_LONG;
          wrData = state_ff.sp + sizeBytes(state_ff.cur.size);
        end else if (state_ff.cur.op inside {cte_pkg::OP_MULTI_RESTORE,
                                             cte_pkg::OP_MULTI_SAVE} &&
                     state_ff.listLeft == 8'h00) begin
          wrEn = 1'b1;
          wrIdx = 4'(cte_pkg::STACK_REG);
          wrSize = cte_pkg::SZ_LONG;
          wrData = state_ff.sp;
        end
        nxt_state.cur.op = cte_pkg::OP_NONE;
        nxt_state.state = ST_IDLE;
      end
      default: nxt_state.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '{state: ST_IDLE, flags: cte_pkg::FLAGS_RESET, default: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign instrReady = (state_ff.state == ST_IDLE);
  assign busy = (state_ff.state != ST_IDLE);
  assign illegal = state_ff.illegal;
  assign conditionFlags = state_ff.flags;
endmodule : cte_exec
`default_nettype wire

// ---- cte_exec_assertions.sv ----
// Checker: refusals, request hold and stack addressing of the unit
`default_nettype none
module cte_exec_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic instrValid,
  input wire cte_pkg::cte_instr_s instr,
  input wire logic instrReady,
  input wire logic illegal,
  input wire cte_pkg::cte_mem_s memReq,
  input wire logic memAck,
  input wire logic [31:0] wideGpr [cte_pkg::NUM_WIDE_GPR]
);
  logic tk;
  logic bt;
  // Taken instruction and byte size
  assign tk = instrValid && instrReady;
  assign bt = instr.size == cte_pkg::SZ_BYTE;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_req_held:
    assert property (memReq.req && !memAck |=> memReq.req && $stable(memReq.addr))
    else $error("request dropped");
  a_ill_once:
    assert property (illegal |=> !illegal) else $error("refusal too long");
  a_periph_off:
    assert property (tk && instr.op == cte_pkg::OP_PERIPH_SYNC_LOAD |=> illegal)
    else $error("sync load taken");
  a_sub_imm:
    assert property (tk && instr.op == cte_pkg::OP_SUB && bt && instr.src == cte_pkg::SRC_IMM
      |=> illegal) else $error("byte imm sub taken");
  a_step_two:
    assert property (tk && instr.op == cte_pkg::OP_STEP_UP && bt && instr.imm[1:0] == 2'h2
      |=> illegal) else $error("byte step two taken");
  a_push_addr:
    assert property (tk && instr.op == cte_pkg::OP_STACK_SAVE && instr.size == cte_pkg::SZ_LONG
      |=> memReq.req && memReq.write && memReq.addr == $past(wideGpr[7]) - 32'h4)
    else $error("push address");
  a_pop_addr:
    assert property (tk && instr.op == cte_pkg::OP_STACK_RESTORE
      |=> memReq.req && !memReq.write && memReq.addr == $past(wideGpr[7]))
    else $error("pop address");
  a_addr_four:
    assert property (tk && instr.op == cte_pkg::OP_ADDR_PLUS && instr.imm[2:0] == 3'h4
      && instr.rd == 4'h3 |=> wideGpr[3] == $past(wideGpr[3]) + 32'h4) else $error("addr add");
endmodule : cte_exec_assertions
bind cte_exec cte_exec_assertions chk (.clk(clk), .nrst(nrst), .instrValid(instrValid),
  .instr(instr), .instrReady(instrReady), .illegal(illegal), .memReq(memReq),
  .memAck(memAck), .wideGpr(wideGpr));
`default_nettype wire

// ---- cte_exec_tb.sv ----
// Testbench: directed instruction sequences for the execution unit
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module cte_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic instrValid = 1'b0;
  logic slow = 1'b0;
  logic [7:0] lst = 8'h00;
  logic ill;
  logic instrReady, illegal, busy, memAck;
  logic [31:0] memRdata;
  logic [7:0] conditionFlags;
  logic [31:0] wideGpr [cte_pkg::NUM_WIDE_GPR];
  cte_pkg::cte_mem_s memReq;
  cte_pkg::cte_instr_s instr = '0;
  int n_fail = 0;
  int tests_run = 0;
  cte_pkg::cte_op_e badOp [6] = '{cte_pkg::OP_PERIPH_SYNC_LOAD, cte_pkg::OP_SUB,
    cte_pkg::OP_CARRY_SUM, cte_pkg::OP_STEP_UP, cte_pkg::OP_ADDR_PLUS, cte_pkg::OP_SIGNED_MULTIPLY};
  logic [11:0] badSz = 12'h910; // Sizes of the refused forms
  always #2.5 clk = ~clk;
  cte_exec dut (.clk(clk), .nrst(nrst), .instrValid(instrValid), .instr(instr),
    .instrReady(instrReady), .illegal(illegal), .busy(busy), .memReq(memReq), .memAck(memAck),
    .memRdata(memRdata), .conditionFlags(conditionFlags), .wideGpr(wideGpr));
  cte_mem_model mem (.clk(clk), .nrst(nrst), .slow(slow), .memReq(memReq), .memAck(memAck),
    .memRdata(memRdata));
  // One instruction; waits until the unit is ready again
  task automatic run(input cte_pkg::cte_op_e op, input logic [1:0] sz, input logic [1:0] src,
    input logic [3:0] rd, input logic [3:0] rs, input logic [31:0] imm);
    @(posedge clk);
    #1;
    instr = '{op, cte_pkg::cte_size_e'(sz), cte_pkg::cte_src_e'(src), 1'b0, rd, rs, imm, 32'h0,
      lst};
    instrValid = 1'b1;
    @(posedge clk);
    #1;
    instrValid = 1'b0;
    ill = illegal;
    for (int i = 0; i < 40 && instrReady !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask : run
  task automatic summarize;
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // Hang guard, far beyond the sequence length
  initial begin
    #50us;
    n_fail++;
    summarize();
  end
  // Main sequence; sizes 0 byte, 1 word, 2 long; source 0 reg, 1 imm
  initial begin
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    `CHK(conditionFlags, cte_pkg::FLAGS_RESET)
    run(cte_pkg::OP_TRANSFER, 2'h2, 2'h1, 4'h0, 4'h0, 32'h1234_5678);
    `CHK(wideGpr[0], 32'h1234_5678)
    run(cte_pkg::OP_TRANSFER, 2'h0, 2'h1, 4'h8, 4'h0, 32'h9a);
    run(cte_pkg::OP_TRANSFER, 2'h1, 2'h0, 4'h1, 4'h8, 32'h0);
    `CHK({wideGpr[0], wideGpr[1]}, 64'h1234_569a_0000_1234)
    run(cte_pkg::OP_ADD, 2'h0, 2'h1, 4'h9, 4'h0, 32'hcc);
    `CHK({wideGpr[1], conditionFlags[3:0]}, 36'h0_0000_1200_5)
    run(cte_pkg::OP_CARRY_SUM, 2'h0, 2'h1, 4'h9, 4'h0, 32'h1);
    `CHK({wideGpr[1], conditionFlags[3:0]}, 36'h0_0000_1202_0)
    for (int k = 0; k < 6; k++) begin
      run(badOp[k], badSz[2*k+:2], 2'h1, 4'h9, 4'h0, 32'h2);
      `CHK(ill, 1'b1)
    end
    run(cte_pkg::OP_STEP_UP, 2'h1, 2'h1, 4'h1, 4'h0, 32'h2);
    `CHK(wideGpr[1], 32'h0000_1204)
    run(cte_pkg::OP_ADDR_PLUS, 2'h2, 2'h1, 4'h3, 4'h0, 32'h4);
    run(cte_pkg::OP_TRANSFER, 2'h2, 2'h1, 4'h2, 4'h0, 32'hfe);
    run(cte_pkg::OP_UNSIGNED_MULTIPLY, 2'h0, 2'h0, 4'ha, 4'hb, 32'h0);
    `CHK(wideGpr[2], 32'h0000_03f8)
    run(cte_pkg::OP_SIGNED_MULTIPLY, 2'h0, 2'h0, 4'ha, 4'hb, 32'h0);
    `CHK(wideGpr[2], 32'h0000_ffe0)
    slow = 1'b1;
    run(cte_pkg::OP_STACK_SAVE, 2'h2, 2'h0, 4'h0, 4'h0, 32'h0);
    `CHK(wideGpr[7], 32'hffff_fffc)
    run(cte_pkg::OP_STACK_RESTORE, 2'h2, 2'h0, 4'h4, 4'h4, 32'h0);
    `CHK({wideGpr[4], wideGpr[7]}, 64'h1234_569a_0000_0000)
    // Two-register list: save, clobber, restore must give the originals back
    lst = 8'h03;
    run(cte_pkg::OP_MULTI_SAVE, 2'h2, 2'h0, 4'h0, 4'h0, 32'h0);
    `CHK(wideGpr[7], 32'hffff_fff8)
    run(cte_pkg::OP_TRANSFER, 2'h2, 2'h1, 4'h0, 4'h0, 32'h0);
    run(cte_pkg::OP_MULTI_RESTORE, 2'h2, 2'h0, 4'h0, 4'h0, 32'h0);
    `CHK({wideGpr[0], wideGpr[1], wideGpr[7]}, 96'h1234_569a_0000_1204_0000_0000)
    summarize();
  end
endmodule : cte_exec_tb
`default_nettype wire

// ---- cte_gpr_file.sv ----
// Register file: eight 32-bit registers aliased as word and byte halves
`default_nettype none
module cte_gpr_file (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] rdIdx,
  input wire cte_pkg::cte_size_e rdSize,
  input wire logic [3:0] rsIdx,
  input wire cte_pkg::cte_size_e rsSize,
  input wire logic wrEn,
  input wire logic [3:0] wrIdx,
  input wire cte_pkg::cte_size_e wrSize,
  input wire logic [31:0] wrData,
  output logic [31:0] rdVal,
  output logic [31:0] rsVal,
  output logic [31:0] spVal,
  output logic [31:0] wideGpr [cte_pkg::NUM_WIDE_GPR]
);
  typedef struct packed {
    logic [cte_pkg::NUM_WIDE_GPR-1:0][31:0] regs;
  } cte_gpr_s;
  cte_gpr_s state_ff;
  cte_gpr_s nxt_state;

  // Alias select: word idx 0-7 low halves, 8-15 high; byte idx 0-7 high bytes, 8-15 low
  function automatic logic [31:0] pick(input cte_gpr_s s, input logic [3:0] idx,
                                       input cte_pkg::cte_size_e sz);
    logic [31:0] r;
    r = s.regs[idx[2:0]];
    case (sz)
      cte_pkg::SZ_BYTE: pick = idx[3] ? {24'h0, r[7:0]} : {24'h0, r[15:8]};
      cte_pkg::SZ_WORD: pick = idx[3] ? {16'h0, r[31:16]} : {16'h0, r[15:0]};
      default: pick = r;
    endcase
  endfunction : pick

  // Read ports, combinational so the unit sees the current value
  always_comb begin
    rdVal = pick(state_ff, rdIdx, rdSize);
    rsVal = pick(state_ff, rsIdx, rsSize);
    spVal = state_ff.regs[cte_pkg::STACK_REG];
    for (int i = 0; i < cte_pkg::NUM_WIDE_GPR; i++) begin
      wideGpr[i] = state_ff.regs[i];
    end
  end

  // Writes touch only the lanes of the addressed alias
  always_comb begin
    nxt_state = state_ff;
    if (wrEn) begin
      case (wrSize)
        cte_pkg::SZ_BYTE: begin
          if (wrIdx[3]) nxt_state.regs[wrIdx[2:0]][7:0] = wrData[7:0];
          else nxt_state.regs[wrIdx[2:0]][15:8] = wrData[7:0];
        end
        cte_pkg::SZ_WORD: begin
          if (wrIdx[3]) nxt_state.regs[wrIdx[2:0]][31:16] = wrData[15:0];
          else nxt_state.regs[wrIdx[2:0]][15:0] = wrData[15:0];
        end
        default: nxt_state.regs[wrIdx[2:0]] = wrData;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule : cte_gpr_file
`default_nettype wire

// ---- cte_mem_model.sv ----
// Memory and stack model answering operand accesses
`default_nettype none
module cte_mem_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire cte_pkg::cte_mem_s memReq,
  output logic memAck,
  output logic [31:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] store [logic [31:0]];
  logic [1:0] waitCnt = 2'h0;
  initial memAck = 1'b0;
  initial memRdata = 32'h0;
  // Write lands at the acking edge; read data only valid with the ack
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitCnt = 2'h0;
      memAck = 1'b0;
    end else begin
      if (memAck && memReq.write) store[memReq.addr] = memReq.wdata;
      #1;
      waitCnt = (memReq.req && !memAck) ? waitCnt + 2'h1 : 2'h0;
      memAck = memReq.req && (waitCnt > (slow ? 2'h2 : 2'h0));
      memRdata = memAck ? store[memReq.addr] : ~memRdata;
    end
  end
endmodule : cte_mem_model
`default_nettype wire

// ---- cte_multiplier.sv ----
// Registered multiplier: 8x8 to 16 or 16x16 to 32, signed or unsigned
`default_nettype none
module cte_multiplier (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic isSigned,
  input wire logic isWord,
  input wire logic [15:0] opA,
  input wire logic [15:0] opB,
  output logic [31:0] product,
  output logic done
);
  typedef struct packed {
    logic [31:0] product;
    logic done;
  } cte_mul_s;
  cte_mul_s state_ff;
  cte_mul_s nxt_state;
  logic signed [16:0] extA;
  logic signed [16:0] extB;
  logic signed [33:0] full;

  // Extend per size and sign, one product serves both sizes
  always_comb begin
    if (isWord) begin
      extA = {isSigned & opA[15], opA};
      extB = {isSigned & opB[15], opB};
    end else begin
      extA = {{9{isSigned & opA[7]}}, opA[7:0]};
      extB = {{9{isSigned & opB[7]}}, opB[7:0]};
    end
    full = extA * extB;
    nxt_state.done = start;
    nxt_state.product = state_ff.product;
    if (start) begin
      nxt_state.product = isWord ? full[31:0] : {16'h0, full[15:0]};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign product = state_ff.product;
  assign done = state_ff.done;
endmodule : cte_multiplier
`default_nettype wire

// ---- cte_pkg.sv ----
// Package: operation codes, sizes, flag layout and carriers for the transfer/arith unit
`default_nettype none
package cte_pkg;
  // Operation selector from the decoder
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_TRANSFER = 5'h01,
    OP_PERIPH_SYNC_LOAD = 5'h02,
    OP_PERIPH_SYNC_STORE = 5'h03,
    OP_STACK_RESTORE = 5'h04,
    OP_STACK_SAVE = 5'h05,
    OP_MULTI_RESTORE = 5'h06,
    OP_MULTI_SAVE = 5'h07,
    OP_ADD = 5'h08,
    OP_SUB = 5'h09,
    OP_CARRY_SUM = 5'h0a,
    OP_BORROW_DIFF = 5'h0b,
    OP_STEP_UP = 5'h0c,
    OP_STEP_DOWN = 5'h0d,
    OP_ADDR_PLUS = 5'h0e,
    OP_ADDR_MINUS = 5'h0f,
    OP_BCD_FIX_SUM = 5'h10,
    OP_BCD_FIX_DIFF = 5'h11,
    OP_UNSIGNED_MULTIPLY = 5'h12,
    OP_SIGNED_MULTIPLY = 5'h13
  } cte_op_e;

  // Operand size
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } cte_size_e;

  // Source of the transfer operand
  typedef enum logic [1:0] {
    SRC_REG = 2'h0,
    SRC_IMM = 2'h1,
    SRC_MEM = 2'h2
  } cte_src_e;

  // Flag bit positions in the condition flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [31:0] GPR_RESET = 32'h0000_0000;
  localparam int STACK_REG = 7;
  localparam int NUM_WIDE_GPR = 8;
  localparam int MUL_LATENCY = 1;

  // Instruction as handed over by the decoder
  typedef struct packed {
    cte_op_e op;
    cte_size_e size;
    cte_src_e src;
    logic toMem;
    logic [3:0] rd;
    logic [3:0] rs;
    logic [31:0] imm;
    logic [31:0] addr;
    logic [7:0] regList;
  } cte_instr_s;

  // One operand access to memory or stack
  typedef struct packed {
    logic req;
    logic write;
    cte_size_e size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cte_mem_s;
endpackage : cte_pkg
`default_nettype wire
